// ---- hdl/ascs_serial.sv ----
// serial port control, status, transmitter and receiver behind an avalon-mm slave
// Function
// - frame is start, 8 data, stop; nine-bit select adds a data bit; unreset
// - ninth received bit readable, ninth transmitted bit writable, both unreset
// - wake select: idle line, or a one in the top data bit
// - while asleep no receiver flag sets; set flags stay; reset clears sleep
// - idle wake clears sleep after 10/11 ones; with idle wake, sleep writes ignored on idle line
// - address wake clears sleep, stores that character and sets receive-full
// - one interrupt from four enabled sources; overrun shares receive enable
// - transmit enable rising sends a preamble of 10/11 ones first
// - clearing transmit enable finishes the character, then releases the pin
// - enable toggled mid character: finish it, then a new preamble, then high
// - receive enable low disables receiver and inhibits its flags
// - send break sends zeros in whole frames, 10/11 for one pulse
// - after any break at least one high bit precedes the next start
// - transmit-empty sets on shift load; status read then data write clears
// - transmit-done sets at end with nothing pending, or with transmit disabled
// - receive-full sets on transfer with noise and framing in the same cycle
// - idle flag after 10/11 ones, rearmed by receive-full, not on wake
// - overrun keeps held data and drops characters until receive-full clears
// - noise flag from sample disagreement on start, data or stop bits
// - missing stop sets framing error, still transfers and sets receive-full
// - framing error plus overrun sets overrun only and drops the character
// - sixteen samples per bit, majority of three, transmit bit of sixteen
// - idle high, low start, least significant bit first, high stop
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps

module ascs_serial #(
	parameter logic [7:0] RT_DIV = ascs_pkg::RT_DIV_DEFAULT
) (
	input wire logic i_clock, // 200 mhz clock
	input wire logic i_srst, // synchronous reset, active high
	input wire logic i_clk_en, // state frozen while low
	input wire logic [4:0] i_address, // avalon byte address
	input wire logic i_read, // avalon read
	input wire logic i_write, // avalon write
	input wire logic [3:0] i_byteenable, // avalon byte enables
	input wire logic [31:0] i_writedata, // avalon write data
	output logic [31:0] o_readdata, // avalon read data
	output logic o_waitrequest, // avalon wait request
	input wire logic i_serial_in_pin, // receive line
	output logic o_serial_out, // transmit line level
	output logic o_serial_out_oe, // transmit line driven
	output logic o_irq // serial interrupt
);
	import ascs_pkg::*;

	ascs_state_t s_r;
	ascs_state_t s_nxt;
	ascs_state_t s_rst;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// vote3 is the majority of the three mid-bit samples; a one-sample
	// glitch therefore never changes a bit, it only raises noise
	function automatic logic vote3(input logic a, input logic b, input logic c);
		vote3 = (a & b) | (a & c) | (b & c);
	endfunction

	function automatic logic [3:0] frame_len(input logic nine);
		frame_len = nine ? LEN_9BIT : LEN_8BIT;
	endfunction

	logic line;
	logic rt_tick;
	logic tx_tick;
	logic req;
	logic accept;
	logic byte0;
	logic bit_v;
	logic bit_noise;
	logic line_idle;
	logic [3:0] len;
	logic [7:0] quiet_target;
	logic [10:0] data_frame;

	// line is the second synchroniser stage; nothing reads the first stage,
	// so a metastable first flop never reaches the receiver logic
	assign line = s_r.sync[1];
	assign len = frame_len(s_r.nine_bit);
	assign quiet_target = s_r.nine_bit ? QUIET_9BIT : QUIET_8BIT;
	assign rt_tick = (s_r.rt_div == RT_DIV - 8'h01);
	assign tx_tick = rt_tick && (s_r.tx_rt == RT_PER_BIT);
	assign req = i_read | i_write;
	assign accept = req & s_r.ack;
	assign byte0 = i_byteenable[0];
	assign bit_v = vote3(s_r.smp[0], s_r.smp[1], line);
	assign bit_noise = !(s_r.smp[0] == s_r.smp[1] && s_r.smp[1] == line);
	assign line_idle = (s_r.rx_st == RX_HUNT) && (s_r.quiet_cnt == quiet_target);
	// start low, data lsb first, ninth bit, high stop; unused top bit idles high
	assign data_frame = {1'b1, s_r.nine_bit ? s_r.transmit_ninth_bit : 1'b1,
		s_r.tx_hold, 1'b0};

	// ------------------------------------------------------------
	// reset value: format bits and ninth bits keep their contents
	// ------------------------------------------------------------
	// the frame format, wake method and ninth bits survive reset, so a
	// warm reset does not change the line format under a running partner;
	// the clear snapshot is zeroed, so no stale status read survives reset
	always_comb begin
		s_rst = '0;
		s_rst.sync = 2'h3;
		s_rst.rx_data = s_r.rx_data;
		s_rst.receive_ninth_bit = s_r.receive_ninth_bit;
		s_rst.transmit_ninth_bit = s_r.transmit_ninth_bit;
		s_rst.nine_bit = s_r.nine_bit;
		s_rst.wake_addr = s_r.wake_addr;
		s_rst.tx_holding_empty = 1'b1;
		s_rst.tx_done = 1'b1;
		s_rst.rx_sr = 9'h1ff;
		s_rst.quiet_armed = 1'b1;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.sync = {s_r.sync[0], i_serial_in_pin};
		s_nxt.rt_div = rt_tick ? 8'h00 : s_r.rt_div + 8'h01;
		if (rt_tick) begin
			s_nxt.tx_rt = s_r.tx_rt + 4'h1;
		end

		// bus: one wait cycle, read data and side effects at the accepting edge
		s_nxt.ack = req & ~s_r.ack;
		if (req && !s_r.ack) begin
			s_nxt.rdata = 32'h0;
			if (i_address == OFF_DATA) begin
				s_nxt.rdata[7:0] = s_r.rx_data;
			end else if (i_address == OFF_FORMAT) begin
				s_nxt.rdata[FMT_RX_NINTH] = s_r.receive_ninth_bit;
				s_nxt.rdata[FMT_TX_NINTH] = s_r.transmit_ninth_bit;
				s_nxt.rdata[FMT_NINE_BIT] = s_r.nine_bit;
				s_nxt.rdata[FMT_WAKE_ADDR] = s_r.wake_addr;
			end else if (i_address == OFF_ENABLE) begin
				s_nxt.rdata[7:0] = {s_r.tx_empty_irq_enable, s_r.tx_complete_irq_enable,
					s_r.rx_irq_enable, s_r.quiet_irq_enable, s_r.tx_enable,
					s_r.rx_enable, s_r.receiver_sleep, s_r.send_break};
			end else if (i_address == OFF_STATUS) begin
				s_nxt.rdata[7:1] = {s_r.tx_holding_empty, s_r.tx_done, s_r.rx_holding_full,
					s_r.quiet, s_r.overrun, s_r.noise_flag, s_r.framing_error_flag};
			end
		end

		if (accept && i_read) begin
			if (i_address == OFF_STATUS) begin
				// arm the clear of every flag seen set by this read; taken from the
				// returned data, so a flag that rises in the wait cycle is not
				// cleared before software has seen it
				s_nxt.snap = s_r.rdata[7:1];
			end else if (i_address == OFF_DATA) begin
				if (s_r.snap[ST_RX_FULL - 1]) s_nxt.rx_holding_full = 1'b0;
				if (s_r.snap[ST_QUIET - 1]) s_nxt.quiet = 1'b0;
				if (s_r.snap[ST_OVERRUN - 1]) s_nxt.overrun = 1'b0;
				if (s_r.snap[ST_NOISE - 1]) s_nxt.noise_flag = 1'b0;
				if (s_r.snap[ST_FRAMING - 1]) s_nxt.framing_error_flag = 1'b0;
				s_nxt.snap[4:0] = 5'h00;
			end
		end

		if (accept && i_write && byte0) begin
			if (i_address == OFF_DATA) begin
				s_nxt.tx_hold = i_writedata[7:0];
				// without the status read first the byte is stored but never sent
				if (s_r.snap[ST_TX_EMPTY - 1]) s_nxt.tx_holding_empty = 1'b0;
				if (s_r.snap[ST_TX_DONE - 1]) s_nxt.tx_done = 1'b0;
				s_nxt.snap[6:5] = 2'h0;
			end else if (i_address == OFF_FORMAT) begin
				s_nxt.transmit_ninth_bit = i_writedata[FMT_TX_NINTH];
				s_nxt.nine_bit = i_writedata[FMT_NINE_BIT];
				s_nxt.wake_addr = i_writedata[FMT_WAKE_ADDR];
			end else if (i_address == OFF_ENABLE) begin
				s_nxt.tx_empty_irq_enable = i_writedata[EN_TX_EMPTY_IRQ];
				s_nxt.tx_complete_irq_enable = i_writedata[EN_TX_DONE_IRQ];
				s_nxt.rx_irq_enable = i_writedata[EN_RX_IRQ];
				s_nxt.quiet_irq_enable = i_writedata[EN_QUIET_IRQ];
				s_nxt.tx_enable = i_writedata[EN_TX];
				s_nxt.rx_enable = i_writedata[EN_RX];
				s_nxt.send_break = i_writedata[EN_BREAK];
				if (i_writedata[EN_BREAK]) begin
					s_nxt.brk_pend = 1'b1;
				end
				if (i_writedata[EN_TX] && !s_r.tx_enable) begin
					s_nxt.pre_pend = 1'b1;
				end
				if (!i_writedata[EN_SLEEP]) begin
					s_nxt.receiver_sleep = 1'b0;
				end else if (!(line_idle && !s_r.wake_addr)) begin
					s_nxt.receiver_sleep = 1'b1;
				end
			end
		end

		// ------------------------------------------------------------
		// transmitter: tx_sr[0] is the bit on the line, tx_cnt bits remain
		// ------------------------------------------------------------
		// priority at a bit boundary: preamble, break, guard bit, data, idle.
		// a new byte waits for the next boundary, so a write that lands on a
		// tick is never overtaken by the stale holding contents.
		// a break pulse shorter than a frame is remembered in brk_pend, so
		// even a set then clear write pair sends one full frame of zeros
		if (tx_tick) begin
			if (s_r.tx_cnt > 4'h1) begin
				s_nxt.tx_sr = {1'b1, s_r.tx_sr[10:1]};
				s_nxt.tx_cnt = s_r.tx_cnt - 4'h1;
			end else if (s_r.tx_enable && s_nxt.pre_pend) begin
				s_nxt.pre_pend = 1'b0;
				s_nxt.tx_sr = 11'h7ff;
				s_nxt.tx_cnt = len;
			end else if (s_r.tx_enable && (s_r.send_break || s_r.brk_pend)) begin
				s_nxt.brk_pend = 1'b0;
				s_nxt.tx_sr = 11'h000;
				s_nxt.tx_cnt = len;
				s_nxt.guard = 1'b1;
			end else if (s_r.guard) begin
				s_nxt.guard = 1'b0;
				s_nxt.tx_sr = 11'h7ff;
				s_nxt.tx_cnt = 4'h1;
			end else if (s_r.tx_enable && !s_r.tx_holding_empty) begin
				s_nxt.tx_sr = data_frame;
				s_nxt.tx_cnt = len;
				s_nxt.tx_holding_empty = 1'b1;
			end else begin
				// nothing pending; a disabled end lets go of the pin here
				s_nxt.tx_cnt = 4'h0;
				if (s_r.tx_cnt == 4'h1) begin
					s_nxt.tx_done = 1'b1;
				end
			end
		end

		// ------------------------------------------------------------
		// receiver, stepped at the sample rate
		// ------------------------------------------------------------
		// rx_rt counts sixteen ticks per bit; samples at ticks 7, 8 and 9.
		// limitation: no edge check after a framing error; the
		// receiver starts a new frame on any low sample while hunting
		if (!s_r.rx_enable) begin
			s_nxt.rx_st = RX_HUNT;
			s_nxt.quiet_cnt = 8'h00;
		end else if (rt_tick) begin
			case (s_r.rx_st)
				RX_HUNT: begin
					if (!line) begin
						s_nxt.rx_st = RX_FRAME;
						s_nxt.rx_rt = 4'h0;
						s_nxt.rx_idx = 4'h0;
						s_nxt.rx_noise = 1'b0;
						s_nxt.quiet_cnt = 8'h00;
					end else if (s_r.quiet_cnt != quiet_target) begin
						s_nxt.quiet_cnt = s_r.quiet_cnt + 8'h01;
						if (s_r.quiet_cnt + 8'h01 == quiet_target) begin
							if (s_r.receiver_sleep) begin
								if (!s_r.wake_addr) begin
									s_nxt.receiver_sleep = 1'b0;
								end
							end else if (s_r.quiet_armed) begin
								s_nxt.quiet = 1'b1;
								s_nxt.quiet_armed = 1'b0;
							end
						end
					end
				end
				RX_FRAME: begin
					s_nxt.rx_rt = s_r.rx_rt + 4'h1;
					if (s_r.rx_rt == RT_SMP_A) s_nxt.smp[0] = line;
					if (s_r.rx_rt == RT_SMP_B) s_nxt.smp[1] = line;
					if (s_r.rx_rt == RT_SMP_C) begin
						s_nxt.rx_idx = s_r.rx_idx + 4'h1;
						if (s_r.rx_idx == 4'h0) begin
							if (bit_v) begin
								s_nxt.rx_st = RX_HUNT; // false start, no noise
							end else begin
								s_nxt.rx_noise = bit_noise;
							end
						end else if (s_r.rx_idx < len - 4'h1) begin
							s_nxt.rx_sr = {bit_v, s_r.rx_sr[8:1]};
							s_nxt.rx_noise = s_r.rx_noise | bit_noise;
						end else begin
							// stop bit: decide the whole character in one cycle
							s_nxt.rx_st = RX_HUNT;
							if (s_r.receiver_sleep && s_r.wake_addr && s_r.rx_sr[8]) begin
								s_nxt.receiver_sleep = 1'b0;
							end
							if (s_r.receiver_sleep && !(s_r.wake_addr && s_r.rx_sr[8])) begin
								s_nxt.rx_noise = 1'b0;
							end else if (s_nxt.rx_holding_full) begin
								s_nxt.overrun = 1'b1;
							end else begin
								s_nxt.rx_data = s_r.nine_bit ? s_r.rx_sr[7:0] : s_r.rx_sr[8:1];
								s_nxt.receive_ninth_bit = s_r.nine_bit ? s_r.rx_sr[8]
									: s_r.receive_ninth_bit;
								s_nxt.rx_holding_full = 1'b1;
								s_nxt.noise_flag = s_r.rx_noise | bit_noise;
								s_nxt.framing_error_flag = ~bit_v;
								s_nxt.quiet_armed = 1'b1;
							end
						end
					end
				end
				default: begin
					s_nxt.rx_st = RX_HUNT;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// the clock enable gates the whole state word at once; a frozen
	// block keeps its counters and flags exactly where they were
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			s_r <= s_rst;
		end else if (i_clk_en) begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// a frozen clock enable also holds the bus, so no accept is lost
	assign o_waitrequest = req & (~s_r.ack | ~i_clk_en);
	assign o_readdata = s_r.rdata;
	assign o_serial_out = (s_r.tx_cnt != 4'h0) ? s_r.tx_sr[0] : 1'b1;
	// the pin stays driven until the last bit of a character has left,
	// even when the enable was cleared earlier
	assign o_serial_out_oe = s_r.tx_enable | (s_r.tx_cnt != 4'h0);
	assign o_irq = (s_r.tx_empty_irq_enable & s_r.tx_holding_empty)
		| (s_r.tx_complete_irq_enable & s_r.tx_done)
		| (s_r.rx_irq_enable & (s_r.rx_holding_full | s_r.overrun))
		| (s_r.quiet_irq_enable & s_r.quiet);

endmodule

// ---- pkg/ascs_pkg.sv ----
// package: register map, field layout, frame timing and state type of the serial port
package ascs_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [4:0] OFF_DATA = 5'h00;
	localparam logic [4:0] OFF_FORMAT = 5'h04;
	localparam logic [4:0] OFF_ENABLE = 5'h08;
	localparam logic [4:0] OFF_STATUS = 5'h0c;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int FMT_RX_NINTH = 7;
	localparam int FMT_TX_NINTH = 6;
	localparam int FMT_NINE_BIT = 4;
	localparam int FMT_WAKE_ADDR = 3;
	localparam int EN_TX_EMPTY_IRQ = 7;
	localparam int EN_TX_DONE_IRQ = 6;
	localparam int EN_RX_IRQ = 5;
	localparam int EN_QUIET_IRQ = 4;
	localparam int EN_TX = 3;
	localparam int EN_RX = 2;
	localparam int EN_SLEEP = 1;
	localparam int EN_BREAK = 0;
	localparam int ST_TX_EMPTY = 7;
	localparam int ST_TX_DONE = 6;
	localparam int ST_RX_FULL = 5;
	localparam int ST_QUIET = 4;
	localparam int ST_OVERRUN = 3;
	localparam int ST_NOISE = 2;
	localparam int ST_FRAMING = 1;

	// ------------------------------------------------------------
	// frame timing, in sample ticks and bits
	// ------------------------------------------------------------
	localparam logic [3:0] RT_PER_BIT = 4'hf;
	localparam logic [3:0] RT_SMP_A = 4'h7;
	localparam logic [3:0] RT_SMP_B = 4'h8;
	localparam logic [3:0] RT_SMP_C = 4'h9;
	localparam logic [3:0] LEN_8BIT = 4'ha;
	localparam logic [3:0] LEN_9BIT = 4'hb;
	localparam logic [7:0] QUIET_8BIT = 8'ha0;
	localparam logic [7:0] QUIET_9BIT = 8'hb0;
	localparam logic [7:0] RT_DIV_DEFAULT = 8'h08;

	typedef enum logic [0:0] {
		RX_HUNT = 1'b0,
		RX_FRAME = 1'b1
	} ascs_rx_state_t;

	typedef struct packed {
		logic [1:0] sync;
		logic [7:0] rx_data;
		logic receive_ninth_bit;
		logic transmit_ninth_bit;
		logic nine_bit;
		logic wake_addr;
		logic tx_empty_irq_enable;
		logic tx_complete_irq_enable;
		logic rx_irq_enable;
		logic quiet_irq_enable;
		logic tx_enable;
		logic rx_enable;
		logic receiver_sleep;
		logic send_break;
		logic tx_holding_empty;
		logic tx_done;
		logic rx_holding_full;
		logic quiet;
		logic overrun;
		logic noise_flag;
		logic framing_error_flag;
		logic [6:0] snap;
		logic ack;
		logic [31:0] rdata;
		logic [7:0] tx_hold;
		logic [7:0] rt_div;
		logic [3:0] tx_rt;
		logic [10:0] tx_sr;
		logic [3:0] tx_cnt;
		logic pre_pend;
		logic guard;
		logic brk_pend;
		ascs_rx_state_t rx_st;
		logic [3:0] rx_rt;
		logic [3:0] rx_idx;
		logic [1:0] smp;
		logic [8:0] rx_sr;
		logic rx_noise;
		logic [7:0] quiet_cnt;
		logic quiet_armed;
	} ascs_state_t;

endpackage

// ---- verification/ascs_line.sv ----
// remote serial node: sends frames to the receive pin and captures transmitted frames
`timescale 1ns/100ps
module ascs_line #(
	parameter int BIT = 16
) (
	input wire logic i_clock, // clock
	input wire logic i_tx, // device transmit level
	input wire logic i_tx_oe, // device drives transmit pin
	input wire logic i_nine, // nine data bits per frame
	output logic o_rx // device receive pin
);
	logic line;
	logic [9:0] rx_q[$];
	// released pin sits on a pull-up, so it reads high
	assign line = i_tx_oe ? i_tx : 1'b1;
	initial o_rx = 1'b1;
	// start, data lsb first, stop, then two idle bits
	task automatic send(input logic [8:0] d, input int n, input logic stp);
		for (int i = 0; i <= n + 3; i++) begin
			@(posedge i_clock);
			o_rx <= (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : (i == n + 1) ? stp : 1'b1;
			repeat (BIT - 1) @(posedge i_clock);
		end
	endtask
	// captured word holds data then stop; a break shows as all zeros
	initial begin
		logic [9:0] f;
		int n;
		forever begin
			@(posedge i_clock);
			if (!line) begin
				f = 10'h000;
				n = i_nine ? 9 : 8;
				repeat (BIT / 2) @(posedge i_clock);
				for (int k = 0; k <= n; k++) begin
					repeat (BIT) @(posedge i_clock);
					f[k] = line;
				end
				rx_q.push_back(f);
				while (!line) @(posedge i_clock);
			end
		end
	end
endmodule

// ---- verification/ascs_serial_assertions.sv ----
// concurrent checks on the serial port's bus and transmit line ports
`timescale 1ns/100ps
module ascs_serial_assertions #(
	parameter logic [7:0] RT_DIV = 8'h08
) (
	input wire logic i_clock, // clock
	input wire logic i_srst, // synchronous reset
	input wire logic i_read, // avalon read
	input wire logic i_write, // avalon write
	input wire logic [31:0] o_readdata, // avalon read data
	input wire logic o_waitrequest, // avalon wait request
	input wire logic o_serial_out, // transmit level
	input wire logic o_serial_out_oe, // transmit driven
	input wire logic o_irq // interrupt
);
	localparam int BIT = 16 * RT_DIV;
	int lo_r;
	int hi_r;
	logic pre_r;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);
	// ----------------------------------------
	// run lengths of the line level
	// ----------------------------------------
	// high run restarts when the pin is taken, so the preamble is measured on its own
	always_ff @(posedge i_clock) begin
		lo_r <= (i_srst || o_serial_out) ? 0 : lo_r + 1;
		hi_r <= (i_srst || !o_serial_out || $rose(o_serial_out_oe)) ? 0 : hi_r + 1;
		pre_r <= i_srst ? 1'b0 : $rose(o_serial_out_oe) ? 1'b1 : (!o_serial_out ? 1'b0 : pre_r);
	end
	sequence one_wait_s;
		o_waitrequest ##1 !o_waitrequest;
	endsequence
	wait_state_a: assert property ($rose(i_read || i_write) |-> one_wait_s)
		else $error("bus request not answered after one wait state");
	irq_reset_a: assert property ($past(i_srst) |-> !o_irq)
		else $error("interrupt high right after reset");
	line_reset_a: assert property ($past(i_srst) |-> o_serial_out && !o_serial_out_oe)
		else $error("transmit pin driven right after reset");
	low_grid_a: assert property ($rose(o_serial_out) && o_serial_out_oe |-> lo_r % BIT == 0)
		else $error("low run not a whole number of bit times");
	start_guard_a: assert property ($fell(o_serial_out) && o_serial_out_oe |-> hi_r >= BIT)
		else $error("start bit without a full high bit before it");
	preamble_a: assert property ($fell(o_serial_out) && pre_r |-> hi_r >= 10 * BIT)
		else $error("first start after enable came before the preamble ended");
	release_end_a: assert property ($fell(o_serial_out_oe) && !$past(i_srst) |->
		o_serial_out && hi_r >= BIT)
		else $error("pin released before the frame ended");
	read_upper_a: assert property (i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h0)
		else $error("read data upper lanes not zero");
endmodule

bind ascs_serial ascs_serial_assertions #(.RT_DIV(RT_DIV)) u_ascs_serial_assertions (
	.i_clock(i_clock), .i_srst(i_srst), .i_read(i_read), .i_write(i_write),
	.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_serial_out(o_serial_out),
	.o_serial_out_oe(o_serial_out_oe), .o_irq(o_irq));

// ---- verification/tb.sv ----
// self-checking bench for the serial port: registers, transmit and receive paths
`timescale 1ns/100ps
module tb;
	import ascs_pkg::*;
	localparam int BIT = 16;
	logic i_clock = 1'b0;
	logic i_srst = 1'b1;
	logic [4:0] adr = 5'h00;
	logic rd_s = 1'b0;
	logic wr_s = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] o_readdata;
	logic o_waitrequest, o_serial_out, o_serial_out_oe, o_irq, rx_pin;
	logic [7:0] rv, d1, d2;
	logic [7:0] fmt = 8'h00;
	logic [7:0] exp_st[4] = '{8'h20, 8'h28, 8'h22, 8'h28};
	logic [9:0] exp_q[$];
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	initial forever #2.5 i_clock = ~i_clock;
	ascs_serial #(.RT_DIV(8'h01)) u_ascs_serial (.i_clock(i_clock), .i_srst(i_srst),
		.i_clk_en(1'b1), .i_address(adr), .i_read(rd_s), .i_write(wr_s), .i_byteenable(4'h1),
		.i_writedata(wdat), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
		.i_serial_in_pin(rx_pin), .o_serial_out(o_serial_out),
		.o_serial_out_oe(o_serial_out_oe), .o_irq(o_irq));
	ascs_line #(.BIT(BIT)) u_ascs_line (.i_clock(i_clock), .i_tx(o_serial_out),
		.i_tx_oe(o_serial_out_oe), .i_nine(fmt[FMT_NINE_BIT]), .o_rx(rx_pin));
	// ----------------------------------------
	// bus, compare and closing tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until the rising edge at which waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
		logic busy;
		@(posedge i_clock);
		adr <= a;
		wdat <= {24'h0, d};
		rd_s <= !w;
		wr_s <= w;
		do begin
			@(posedge i_clock);
			busy = o_waitrequest;
			q = o_readdata[7:0];
		end while (busy);
		rd_s <= 1'b0;
		wr_s <= 1'b0;
	endtask
	task automatic wait_empty();
		rv = 8'h00;
		while (!rv[ST_TX_EMPTY]) bus(1'b0, OFF_STATUS, 8'h00, rv);
	endtask
	task automatic put(input logic [7:0] d);
		wait_empty();
		bus(1'b1, OFF_DATA, d, rv);
		exp_q.push_back(fmt[FMT_NINE_BIT] ? {1'b1, fmt[FMT_TX_NINTH], d} : {2'b01, d});
	endtask
	task automatic txchk();
		while (exp_q.size() > 0) begin
			while (u_ascs_line.rx_q.size() == 0) @(posedge i_clock);
			chk("tx frame", exp_q.pop_front(), u_ascs_line.rx_q.pop_front());
		end
	endtask
	task automatic rxchk(input logic [7:0] est, input logic [7:0] ed);
		@(negedge i_clock);
		chk("irq", {9'h0, est != 8'h00}, {9'h0, o_irq});
		bus(1'b0, OFF_STATUS, 8'h00, rv);
		chk("status", {2'b0, est}, {2'b0, rv & 8'h2e});
		bus(1'b0, OFF_DATA, 8'h00, rv);
		if (est != 8'h00) chk("rx data", {2'b0, ed}, {2'b0, rv});
		@(negedge i_clock);
		chk("irq clear", 10'h000, {9'h0, o_irq});
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// hang guard: whole run needs well under this many cycles
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(96343));
		repeat (5) @(posedge i_clock);
		i_srst <= 1'b0;
		bus(1'b0, OFF_STATUS, 8'h00, rv);
		chk("status reset", 10'h0c0, {2'b0, rv});
		bus(1'b0, OFF_ENABLE, 8'h00, rv);
		chk("enable reset", 10'h000, {2'b0, rv});
		bus(1'b0, 5'h10, 8'h00, rv);
		chk("unmapped", 10'h000, {2'b0, rv});
		bus(1'b1, OFF_FORMAT, fmt, rv);
		$display("test registers done");
		bus(1'b1, OFF_ENABLE, 8'h08, rv);
		for (int i = 0; i < 3; i++) put(8'($urandom));
		wait_empty();
		bus(1'b1, OFF_ENABLE, 8'h00, rv);
		txchk();
		repeat (2 * BIT) @(posedge i_clock);
		chk("pin released", 10'h000, {9'h0, o_serial_out_oe});
		bus(1'b0, OFF_STATUS, 8'h00, rv);
		chk("tx flags", 10'h0c0, {2'b0, rv & 8'hc0});
		bus(1'b1, OFF_ENABLE, 8'h08, rv);
		bus(1'b1, OFF_ENABLE, 8'h09, rv);
		bus(1'b1, OFF_ENABLE, 8'h08, rv);
		exp_q.push_back(10'h000);
		txchk();
		$display("test transmit done");
		bus(1'b1, OFF_ENABLE, 8'h24, rv);
		for (int i = 0; i < 4; i++) begin
			d1 = 8'($urandom);
			d2 = 8'($urandom);
			u_ascs_line.send({1'b0, d1}, 8, i != 2);
			if (i % 2 == 1) u_ascs_line.send({1'b0, d2}, 8, i != 3);
			rxchk(exp_st[i], d1);
		end
		$display("test receive done");
		fmt = 8'h50;
		bus(1'b1, OFF_FORMAT, fmt, rv);
		d1 = 8'($urandom);
		u_ascs_line.send({1'b1, d1}, 9, 1'b1);
		rxchk(8'h20, d1);
		bus(1'b0, OFF_FORMAT, 8'h00, rv);
		chk("rx ninth", 10'h001, {9'h0, rv[FMT_RX_NINTH]});
		bus(1'b1, OFF_ENABLE, 8'h2c, rv);
		put(8'($urandom));
		txchk();
		$display("test nine bit done");
		fmt = 8'h08;
		bus(1'b1, OFF_FORMAT, fmt, rv);
		bus(1'b1, OFF_ENABLE, 8'h26, rv);
		u_ascs_line.send(9'h012, 8, 1'b1);
		rxchk(8'h00, 8'h00);
		d1 = 8'($urandom) | 8'h80;
		u_ascs_line.send({1'b0, d1}, 8, 1'b1);
		rxchk(8'h20, d1);
		bus(1'b0, OFF_ENABLE, 8'h00, rv);
		chk("sleep cleared", 10'h024, {2'b0, rv});
		$display("test wake done");
		tally_and_finish();
	end
endmodule
